// file: design/accel_consts.svh
// Constants for the accelerometer readout core: rates, dividers, register offsets.
// Assumes a 20 MHz core clock; included by the readout core and the host master model.
`ifndef ACCEL_CONSTS_SVH
`define ACCEL_CONSTS_SVH

// -----------------------------------------------------------------
// Clock rates and derived divider counts
// -----------------------------------------------------------------
`define CORE_CLK_HZ   20000000
`define AMP_CLK_HZ    61500
`define ADC_CLK_HZ    20500
`define AMP_DIV       (`CORE_CLK_HZ / `AMP_CLK_HZ)
`define ADC_PER_AMP   (`AMP_CLK_HZ / `ADC_CLK_HZ)
`define RATE_MIN_HZ   40
`define RATE_MAX_HZ   2560
`define DEC_MAX       (`ADC_CLK_HZ / `RATE_MIN_HZ)

// -----------------------------------------------------------------
// Host port
// -----------------------------------------------------------------
`define SLAVE_ADDR    7'h1D
`define ADDR_WHO      7'h0F
`define ADDR_STATUS   7'h27
`define ADDR_OUT_BASE 7'h28
`define ADDR_OUT_LAST 7'h2D

// -----------------------------------------------------------------
// Trim storage
// -----------------------------------------------------------------
`define TRIM_WORDS    3'h6
`define TRIM_SHIFT    7
`define ZERO_SHIFT    4

`endif

// file: design/accel_pkg.sv
// Types shared by the accelerometer readout core.
// Assumes accel_consts.svh sits on the include path.
package accel_pkg;

    typedef enum logic [2:0] {
        PORT_IDLE     = 3'b000,
        PORT_ADDR     = 3'b001,
        PORT_SUB      = 3'b010,
        PORT_DATA_IN  = 3'b011,
        PORT_DATA_OUT = 3'b100,
        PORT_IGNORE   = 3'b101
    } port_state_type;

    typedef enum logic [1:0] {
        EVT_NONE      = 2'b00,
        EVT_WAKE      = 2'b01,
        EVT_FREE_FALL = 2'b10,
        EVT_DIRECTION = 2'b11
    } event_sel_type;

endpackage

// file: design/accel_readout.sv
// Accelerometer readout core: conversion timing, filters, trim load, events, host port.
// Assumes all inputs synchronous to core_clk_i; pads resolved outside from the enables.
`timescale 1ns/1ps
`include "accel_consts.svh"

// Notes on behaviour
// RULE1 - chip select high I2C, low SPI
// RULE2 - clock and data pads shared by both
// RULE3 - 3-wire SPI reads drive the data pad
// RULE4 - otherwise reads drive data-out, data pad input
// RULE5 - three converters; amplifier and converter tick rates
// RULE6 - each bit stream filtered into words
// RULE7 - word rate set by decimation ratio
// RULE8 - data ready on each new three-axis set
// RULE9 - wake, direction, free-fall interrupts on enabled axes
// RULE10 - trim copied from storage at power-up
// RULE11 - sub-address: seven address bits, top auto-increments; SPI uses six, bit 6 auto-increments
// RULE12 - host repeats start before an I2C read
// RULE13 - no data ready or interrupt before trim
module accel_readout
    import accel_pkg::*;
#(
    parameter logic [7:0] WHO_VALUE = 8'h5A  // Arbitrary identity value
)(
    input  wire logic              core_clk_i,
    input  wire logic              srst_i,
    input  wire logic              cs_i,
    input  wire logic              serial_port_clock_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    output logic                   sdo_o,
    output logic                   sdo_oe_o,
    input  wire logic              three_wire_i,
    input  wire logic [1:0]        decimation_ratio_i,
    input  wire logic [2:0]        axis_en_i,
    input  wire logic [2:0]        sd_bit_i,
    output logic                   amp_clk_o,
    output logic                   adc_clk_o,
    output logic [2:0]             nvm_addr_o,
    input  wire logic [7:0]        nvm_data_i,
    input  wire event_sel_type     event_sel_i,
    input  wire logic [14:0]       threshold_i,
    input  wire logic              int_ack_i,
    output logic                   int_o,
    output logic                   data_ready_o
);
    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic [8:0]         amp_cnt, next_amp_cnt;
    logic [1:0]         adc_ph, next_adc_ph;
    logic [9:0]         dec_cnt, next_dec_cnt;
    logic               set_pend, next_set_pend;
    logic               next_amp_clk, next_adc_clk, next_int;
    logic [2:0]         prev_sign, next_prev_sign;
    logic [9:0]         ratio;
    logic               dump;
    logic               event_hit;
    logic [2:0]         boot_idx, next_boot_idx;
    logic               boot_done, next_boot_done;
    logic [7:0]         trim [6];
    logic [7:0]         next_trim [6];
    logic signed [15:0] raw [3];
    logic signed [15:0] acc [3];
    logic [2:0]         over, under;
    port_state_type     state, next_state;
    logic [3:0]         cnt, next_cnt;
    logic [7:0]         sreg, next_sreg, tx, next_tx, read_byte;
    logic [6:0]         reg_addr, next_reg_addr;
    logic               auto_inc, next_auto_inc, ack_pend, next_ack_pend;
    logic               out_bit, next_out_bit, out_en, next_out_en;
    logic               scl_q, sda_q, cs_q, next_data_ready;
    logic               scl_rise, scl_fall;

    // -----------------------------------------------------------------
    // Trim load from non-volatile storage
    // -----------------------------------------------------------------
    always_comb begin
        next_trim      = trim;
        next_boot_idx  = boot_idx;
        next_boot_done = boot_done;
        if (!boot_done) begin  // see RULE10
            if (boot_idx != 3'h0) begin
                next_trim[boot_idx - 3'h1] = nvm_data_i;
            end
            if (boot_idx == `TRIM_WORDS) begin
                next_boot_done = 1'b1;
            end else begin
                next_boot_idx = boot_idx + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            boot_idx  <= 3'h0;
            boot_done <= 1'b0;
            trim      <= '{default: 8'h00};
        end else begin
            boot_idx  <= next_boot_idx;
            boot_done <= next_boot_done;
            trim      <= next_trim;
        end
    end

    assign nvm_addr_o = boot_idx;

    // -----------------------------------------------------------------
    // Per-axis filter and trim correction
    // -----------------------------------------------------------------
    assign ratio = 10'(`DEC_MAX) >> {decimation_ratio_i, 1'b0};  // see RULE7
    assign dump  = next_adc_clk && (dec_cnt == ratio - 10'h001);

    for (genvar a = 0; a < 3; a++) begin : g_axis
        logic signed [16:0] diff;
        logic signed [25:0] prod;
        axis_filter u_filter (  // see RULE5, see RULE6
            .core_clk_i   (core_clk_i),
            .srst_i       (srst_i),
            .bit_strobe_i (next_adc_clk),
            .bit_i        (sd_bit_i[a]),
            .dump_i       (dump),
            .ratio_sel_i  (decimation_ratio_i),
            .ratio_i      (ratio),
            .word_o       (raw[a])
        );
        assign diff     = 17'(raw[a]) - (17'($signed(trim[a + 3])) <<< `ZERO_SHIFT);
        assign prod     = 26'(diff) * $signed({18'h00000, trim[a]});
        assign acc[a]   = 16'(prod >>> `TRIM_SHIFT);
        assign over[a]  = axis_en_i[a] && (acc[a] > $signed({1'b0, threshold_i}));
        assign under[a] = !axis_en_i[a] || (acc[a] < $signed({1'b0, threshold_i})
                          && acc[a] > -$signed({1'b0, threshold_i}));
    end

    // -----------------------------------------------------------------
    // Conversion timing, data sets and events
    // -----------------------------------------------------------------
    always_comb begin
        next_amp_cnt = (amp_cnt == 9'(`AMP_DIV - 1)) ? 9'h000 : amp_cnt + 9'h001;
        next_amp_clk = (amp_cnt == 9'(`AMP_DIV - 1));  // see RULE5
        next_adc_ph  = adc_ph;
        next_adc_clk = 1'b0;
        if (next_amp_clk) begin
            next_adc_ph  = (adc_ph == 2'(`ADC_PER_AMP - 1)) ? 2'h0 : adc_ph + 2'h1;
            next_adc_clk = (adc_ph == 2'(`ADC_PER_AMP - 1));
        end
        next_dec_cnt = dec_cnt;
        if (next_adc_clk) begin
            next_dec_cnt = dump ? 10'h000 : dec_cnt + 10'h001;  // see RULE7
        end
        next_set_pend  = dump;
        next_prev_sign = set_pend ? {acc[2][15], acc[1][15], acc[0][15]} : prev_sign;
        case (event_sel_i)  // see RULE9
            EVT_WAKE:      event_hit = |over;
            EVT_FREE_FALL: event_hit = (&under) && (|axis_en_i);
            EVT_DIRECTION: event_hit = |(axis_en_i & (prev_sign ^
                                         {acc[2][15], acc[1][15], acc[0][15]}));
            default:       event_hit = 1'b0;
        endcase
        next_int = int_ack_i ? 1'b0 : int_o;
        if (set_pend && boot_done && event_hit) begin  // see RULE9, see RULE13
            next_int = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            amp_cnt   <= 9'h000;
            adc_ph    <= 2'h0;
            dec_cnt   <= 10'h000;
            set_pend  <= 1'b0;
            amp_clk_o <= 1'b0;
            adc_clk_o <= 1'b0;
            prev_sign <= 3'h0;
            int_o     <= 1'b0;
        end else begin
            amp_cnt   <= next_amp_cnt;
            adc_ph    <= next_adc_ph;
            dec_cnt   <= next_dec_cnt;
            set_pend  <= next_set_pend;
            amp_clk_o <= next_amp_clk;
            adc_clk_o <= next_adc_clk;
            prev_sign <= next_prev_sign;
            int_o     <= next_int;
        end
    end

    // -----------------------------------------------------------------
    // Host port, shared I2C and SPI engine
    // -----------------------------------------------------------------
    assign scl_rise = serial_port_clock_i && !scl_q;
    assign scl_fall = !serial_port_clock_i && scl_q;

    always_comb begin
        case (reg_addr)
            `ADDR_WHO:           read_byte = WHO_VALUE;
            `ADDR_STATUS:        read_byte = {7'h00, data_ready_o};
            `ADDR_OUT_BASE:      read_byte = acc[0][7:0];
            `ADDR_OUT_BASE + 7'h01: read_byte = acc[0][15:8];
            `ADDR_OUT_BASE + 7'h02: read_byte = acc[1][7:0];
            `ADDR_OUT_BASE + 7'h03: read_byte = acc[1][15:8];
            `ADDR_OUT_BASE + 7'h04: read_byte = acc[2][7:0];
            `ADDR_OUT_LAST:      read_byte = acc[2][15:8];
            default:             read_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_state = state;  next_cnt = cnt;  next_sreg = sreg;  next_tx = tx;
        next_reg_addr = reg_addr;  next_auto_inc = auto_inc;  next_ack_pend = ack_pend;
        next_out_bit = out_bit;  next_out_en = out_en;  next_data_ready = data_ready_o;
        if (!cs_i) begin  // see RULE1
            if (cs_q) begin
                next_state  = PORT_SUB;
                next_cnt    = 4'h0;
                next_out_en = 1'b0;
            end else if (scl_rise) begin  // see RULE2
                next_sreg = {sreg[6:0], sda_i};
                next_cnt  = (cnt == 4'h7) ? 4'h0 : cnt + 4'h1;
                if (cnt == 4'h7 && state == PORT_SUB) begin
                    next_reg_addr = {1'b0, next_sreg[5:0]};
                    next_auto_inc = next_sreg[6];
                    next_state    = next_sreg[7] ? PORT_DATA_OUT : PORT_DATA_IN;
                end else if (cnt == 4'h7 && auto_inc) begin
                    next_reg_addr = reg_addr + 7'h01;
                end
            end
        end else if (!cs_q) begin
            next_state  = PORT_IDLE;
            next_out_en = 1'b0;
        end else if (serial_port_clock_i && scl_q && sda_q != sda_i) begin
            next_state    = sda_i ? PORT_IDLE : PORT_ADDR;  // see RULE12
            next_cnt      = 4'h0;
            next_out_en   = 1'b0;
            next_ack_pend = 1'b0;
        end else if (scl_rise && state != PORT_IDLE && state != PORT_IGNORE) begin
            if (cnt == 4'h8) begin
                next_cnt      = 4'h0;
                next_ack_pend = 1'b0;
                if (state == PORT_DATA_OUT && !ack_pend && sda_i) begin
                    next_state = PORT_IGNORE;
                end
            end else begin
                next_sreg = {sreg[6:0], sda_i};
                next_cnt  = cnt + 4'h1;
                if (cnt == 4'h7) begin
                    next_ack_pend = (state != PORT_DATA_OUT);
                    case (state)
                        PORT_ADDR: begin
                            if (next_sreg[7:1] == `SLAVE_ADDR) begin
                                next_state = next_sreg[0] ? PORT_DATA_OUT : PORT_SUB;
                            end else begin
                                next_state    = PORT_IGNORE;
                                next_ack_pend = 1'b0;
                            end
                        end
                        PORT_SUB: begin  // see RULE11
                            next_reg_addr = next_sreg[6:0];
                            next_auto_inc = next_sreg[7];
                            next_state    = PORT_DATA_IN;
                        end
                        default: begin
                            next_reg_addr = auto_inc ? reg_addr + 7'h01 : reg_addr;
                        end
                    endcase
                end
            end
        end
        if (scl_fall && cs_i && cnt == 4'h8) begin
            next_out_en  = ack_pend;
            next_out_bit = 1'b0;
        end else if (scl_fall && state == PORT_DATA_OUT && cs_i == cs_q) begin
            next_out_en  = 1'b1;
            next_out_bit = (cnt == 4'h0) ? read_byte[7] : tx[7];
            next_tx      = (cnt == 4'h0) ? {read_byte[6:0], 1'b0} : {tx[6:0], 1'b0};
            if (cnt == 4'h0 && reg_addr == `ADDR_OUT_LAST) begin
                next_data_ready = 1'b0;
            end
        end else if (scl_fall && cs_i) begin
            next_out_en = 1'b0;
        end
        if (set_pend && boot_done) begin  // see RULE8, see RULE13
            next_data_ready = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= PORT_IDLE;  cnt <= 4'h0;  sreg <= 8'h00;  tx <= 8'h00;
            reg_addr <= 7'h00;  auto_inc <= 1'b0;  ack_pend <= 1'b0;
            out_bit <= 1'b0;  out_en <= 1'b0;  data_ready_o <= 1'b0;
            scl_q <= 1'b1;  sda_q <= 1'b1;  cs_q <= 1'b1;
        end else begin
            state <= next_state;  cnt <= next_cnt;  sreg <= next_sreg;  tx <= next_tx;
            reg_addr <= next_reg_addr;  auto_inc <= next_auto_inc;
            ack_pend <= next_ack_pend;  out_bit <= next_out_bit;  out_en <= next_out_en;
            data_ready_o <= next_data_ready;
            scl_q <= serial_port_clock_i;  sda_q <= sda_i;  cs_q <= cs_i;
        end
    end

    assign sda_o    = cs_i ? 1'b0 : out_bit;  // see RULE2
    // Drive only once the registered select agrees, so a stale bit never leaks across modes
    assign sda_oe_o = cs_i ? (cs_q && out_en && !out_bit)
                           : (!cs_q && three_wire_i && out_en);  // see RULE3
    assign sdo_o    = out_bit;
    assign sdo_oe_o = !cs_i && !cs_q && !three_wire_i && out_en;  // see RULE4

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence boot_start_seq;
        $fell(srst_i);
    endsequence
    sequence boot_end_seq;
        ##[6:8] boot_done;
    endsequence

    AST_I2C_NO_SDO: assert property (cs_i |-> !sdo_oe_o)  // see RULE1
        else $error("data-out pad driven in I2C mode");
    AST_I2C_OPEN_DRAIN: assert property (cs_i && sda_oe_o |-> !sda_o)  // see RULE2
        else $error("data pad driven high in I2C mode");
    AST_THREE_WIRE: assert property (!cs_i && three_wire_i |-> !sdo_oe_o)  // see RULE3
        else $error("data-out pad driven in 3-wire mode");
    AST_FOUR_WIRE: assert property (!cs_i && !three_wire_i |-> !sda_oe_o)  // see RULE4
        else $error("data pad driven in 4-wire SPI mode");
    AST_ADC_ON_AMP: assert property (adc_clk_o |-> amp_clk_o ##1 !amp_clk_o[*8])  // see RULE5
        else $error("converter tick off the amplifier grid");
    AST_DEC_BOUND: assert property (adc_clk_o |-> dec_cnt < ratio)  // see RULE7
        else $error("decimation count past ratio");
    AST_DATA_READY: assert property (set_pend && boot_done |=> data_ready_o)  // see RULE8
        else $error("data ready missed a new set");
    AST_INT_CAUSE: assert property ($rose(int_o) |-> $past(set_pend && event_hit))  // see RULE9
        else $error("interrupt without an event");
    AST_BOOT_LOAD: assert property (boot_start_seq |-> boot_end_seq)  // see RULE10
        else $error("trim load did not finish in time");
    AST_FIXED_ADDR: assert property (state == PORT_DATA_OUT && cs_i && scl_rise  // see RULE11
        && cnt == 4'h7 && !auto_inc |=> $stable(reg_addr))
        else $error("address moved without auto-increment");
    AST_BOOT_QUIET: assert property (!boot_done |-> !data_ready_o && !int_o)  // see RULE13
        else $error("ready or interrupt before trim load");
endmodule

// file: design/axis_filter.sv
// Reconstruction filter for one axis: counts converter ones over a decimation window.
// Assumes bit strobes at the converter rate and a dump strobe on the window's last bit.
`timescale 1ns/1ps
module axis_filter
    import accel_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              srst_i,
    input  wire logic              bit_strobe_i,
    input  wire logic              bit_i,
    input  wire logic              dump_i,
    input  wire logic [1:0]        ratio_sel_i,
    input  wire logic [9:0]        ratio_i,
    output logic signed [15:0]     word_o
);
    logic [9:0]         ones;
    logic [9:0]         next_ones;
    logic signed [15:0] next_word;
    logic [9:0]         total;
    logic signed [15:0] centred;

    // -----------------------------------------------------------------
    // Integrate and dump
    // -----------------------------------------------------------------
    always_comb begin
        total     = ones + {9'h000, bit_strobe_i & bit_i};
        centred   = $signed({5'h00, total, 1'b0}) - $signed({6'h00, ratio_i});
        next_ones = bit_strobe_i ? total : ones;
        next_word = word_o;
        if (dump_i) begin
            next_ones = 10'h000;
            next_word = centred <<< (4'h5 + {1'b0, ratio_sel_i, 1'b0});
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ones   <= 10'h000;
            word_o <= 16'sh0000;
        end else begin
            ones   <= next_ones;
            word_o <= next_word;
        end
    end
endmodule

// file: sim/accel_readout_tb.sv
// Bench for the readout core: boot, tick rates, data path, SPI and I2C reads, events.
// Assumes host_master drives the serial pads; trim storage is modelled here.
`timescale 1ns/1ps
module accel_readout_tb;
    import accel_pkg::*;
    localparam logic [7:0] WHO = 8'hA6;  // Arbitrary identity value
    logic core_clk = 1'b0, srst = 1'b1, three_wire = 1'b0, int_ack = 1'b0;
    logic [2:0] axis_en = 3'h1;
    logic [7:0] nvm_data = 8'h00;
    event_sel_type event_sel = EVT_WAKE;
    logic [14:0] threshold = 15'h1000;
    logic cs, sck, host_sda, sda_o, sda_oe, sdo_o, sdo_oe, amp_clk, adc_clk;
    logic int_o, data_ready, sda_line;
    logic [2:0] nvm_addr;
    logic [1:0] oe_seen = 2'b00;
    int error_cnt = 0, num_checks = 0, cycles = 0;
    always #25 core_clk = ~core_clk;
    assign sda_line = sda_oe ? sda_o : host_sda;
    always @(negedge core_clk) begin
        nvm_data <= (nvm_addr >= 3'h1 && nvm_addr <= 3'h3) ? 8'h80 : 8'h00;
        oe_seen <= oe_seen | {sda_oe, sdo_oe};
    end
    accel_readout #(.WHO_VALUE(WHO)) u_dut (
        .core_clk_i(core_clk), .srst_i(srst), .cs_i(cs), .serial_port_clock_i(sck),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe), .three_wire_i(three_wire), .decimation_ratio_i(2'h3),
        .axis_en_i(axis_en), .sd_bit_i(3'h7), .amp_clk_o(amp_clk), .adc_clk_o(adc_clk),
        .nvm_addr_o(nvm_addr), .nvm_data_i(nvm_data), .event_sel_i(event_sel),
        .threshold_i(threshold), .int_ack_i(int_ack), .int_o(int_o),
        .data_ready_o(data_ready));
    host_master u_host (
        .core_clk_i(core_clk), .sda_line_i(sda_line), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe),
        .cs_o(cs), .sck_o(sck), .sda_o(host_sda));
    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic gap(input bit use_adc, input int lim, output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((use_adc ? adc_clk : amp_clk) !== 1'b1 && n < lim);
    endtask
    task automatic wait_ready();
        for (int n = 0; n < 9000 && data_ready !== 1'b1; n++) @(negedge core_clk);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 50000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_boot();
        repeat (8) @(negedge core_clk);
        check(nvm_addr, 16'h0006);
        check({int_o, data_ready}, 16'h0000);
        $display("boot test done");
    endtask
    task automatic t_ticks();
        int n;
        gap(0, 400, n);
        gap(0, 400, n);
        check(16'(n), 16'h0145);
        gap(1, 1100, n);
        check(amp_clk, 16'h0001);
        gap(1, 1100, n);
        check(16'(n), 16'h03CF);
        $display("tick test done");
    endtask
    task automatic t_spi(input logic three, input logic [7:0] hdr,
                         input logic [7:0] exp, input logic [1:0] oe_exp);
        logic [7:0] d;
        @(posedge core_clk);
        oe_seen = 2'b00;
        @(negedge core_clk);
        three_wire = three;
        u_host.spi_read(hdr, three, d);
        check(d, exp);
        check(oe_seen, oe_exp);
        $display("spi read test done");
    endtask
    task automatic t_i2c();
        logic [7:0] d;
        logic [2:0] acks;
        u_host.i2c_read(7'h0F, d, acks);
        check(acks, 16'h0000);
        check(d, WHO);
        $display("i2c test done");
    endtask
    task automatic t_event();
        axis_en = 3'h1;
        int_ack = 1'b1;
        @(negedge core_clk);
        int_ack = 1'b0;
        @(negedge core_clk);
        check(int_o, 16'h0000);
        wait_ready();
        check(int_o, 16'h0001);
        int_ack = 1'b1;
        @(negedge core_clk);
        int_ack = 1'b0;
        @(negedge core_clk);
        check(int_o, 16'h0000);
        axis_en = 3'h0;
        t_spi(1'b0, 8'hAD, 8'h40, 2'b01);
        wait_ready();
        check({int_o, data_ready}, 16'h0001);
        event_sel = EVT_FREE_FALL;
        axis_en   = 3'h7;
        threshold = 15'h7FFF;
        t_spi(1'b0, 8'hAD, 8'h40, 2'b01);
        wait_ready();
        check(int_o, 16'h0001);
        $display("event test done");
    endtask
    initial begin
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        t_boot();
        t_ticks();
        wait_ready();
        check(data_ready, 16'h0001);
        t_spi(1'b0, 8'hA7, 8'h01, 2'b01);
        t_spi(1'b0, 8'hAD, 8'h40, 2'b01);
        check(data_ready, 16'h0000);
        t_spi(1'b1, 8'h8F, WHO, 2'b10);
        t_i2c();
        t_event();
        print_verdict();
    end
endmodule

// file: sim/host_master_model.sv
// Host master model: SPI or I2C master on the shared serial pads.
// Assumes the bench resolves the shared data pad (the core's value while it drives, else sda_o) and feeds it back.
`timescale 1ns/1ps
`include "accel_consts.svh"
module host_master (
    input  wire logic core_clk_i,
    input  wire logic sda_line_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      cs_o,
    output logic      sck_o,
    output logic      sda_o
);
    logic sdo_last = 1'b0;
    logic sdo_line;
    initial begin
        cs_o = 1'b1;
        sck_o = 1'b1;
        sda_o = 1'b1;
    end
    // Undriven data-out pad shows the inverse of its last value
    assign sdo_line = sdo_oe_i ? sdo_i : ~sdo_last;
    always @(negedge core_clk_i) begin
        if (sdo_oe_i) begin
            sdo_last <= sdo_i;
        end
    end
    task automatic half();
        repeat (4) @(negedge core_clk_i);
    endtask
    task automatic i2c_bit(input logic b, output logic r);
        sda_o = b;
        half();
        sck_o = 1'b1;
        half();
        r = sda_line_i;
        sck_o = 1'b0;
    endtask
    task automatic i2c_start();
        sda_o = 1'b1;
        half();
        sck_o = 1'b1;
        half();
        sda_o = 1'b0;
        half();
        sck_o = 1'b0;
    endtask
    task automatic i2c_byte(input logic [7:0] tx, input logic ack_tx,
                            output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(tx[i], rx[i]);
        end
        i2c_bit(ack_tx, ack_rx);
    endtask
    // Write phase for the sub-address, then repeated start and one read
    task automatic i2c_read(input logic [6:0] addr, output logic [7:0] data,
                            output logic [2:0] acks);
        logic [7:0] junk;
        logic       nack;
        i2c_start();
        i2c_byte({`SLAVE_ADDR, 1'b0}, 1'b1, junk, acks[2]);
        i2c_byte({1'b0, addr}, 1'b1, junk, acks[1]);
        i2c_start();
        i2c_byte({`SLAVE_ADDR, 1'b1}, 1'b1, junk, acks[0]);
        i2c_byte(8'hFF, 1'b1, data, nack);
        sda_o = 1'b0;
        half();
        sck_o = 1'b1;
        half();
        sda_o = 1'b1;
        half();
    endtask
    task automatic spi_read(input logic [7:0] hdr, input logic three,
                            output logic [7:0] d);
        cs_o = 1'b0;
        half();
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            sda_o = hdr[i];
            half();
            sck_o = 1'b1;
            half();
        end
        sda_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            half();
            d[i] = three ? sda_line_i : sdo_line;
            sck_o = 1'b1;
            half();
        end
        cs_o = 1'b1;
        half();
    endtask
endmodule
